// [design/sipo_pkg.sv]
package sipo_pkg;
	localparam int          SIPO_STAGES      = 8;
	localparam int          SIPO_BUF_DEPTH   = 2;
	localparam logic        SIPO_STAGE_RESET = 1'h0;
	localparam logic        SIPO_FIRST_STAGE = 1'h0;
	localparam logic        SIPO_SET         = 1'h1;
	localparam logic        SIPO_OFF         = 1'h0;
endpackage : sipo_pkg

// [design/sipo_shift8.sv]
// Function
// - Eight chained stages, each on parallel output.
// - Serial bit is AND of both inputs.
// - Stages shift on a shift clock rise, or later once buffer room frees for a parked rise.
// - First loads serial bit, others shift along.
// - Last stage value dropped, no carry flag.
// - Low wipe input zeroes all stages.
// - Wipe overrides shifting and serial inputs.
module sipo_shift8 #(
	parameter int STAGES = sipo_pkg::SIPO_STAGES
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	// Host pins
	input  wire logic              ser_a,
	input  wire logic              ser_b,
	input  wire logic              shift_clk,
	input  wire logic              stage_wipe_n,
	// Parallel stage outputs
	output logic [STAGES-1:0]      stage_out,
	output logic                   last_stage_out,
	// Word stream out of the two-entry buffer
	output logic [STAGES-1:0]      word_data,
	output logic                   word_valid,
	input  wire logic              word_ready,
	output logic                   buf_full
);
	import sipo_pkg::*;

	logic [STAGES-1:0] stage_q;
	logic [STAGES-1:0] stage_d;
	logic              shift_clk_q;
	logic              pend_q;
	logic              pend_bit_q;
	logic [STAGES-1:0] head_q;
	logic [STAGES-1:0] tail_q;
	logic              head_v_q;
	logic              tail_v_q;

	wire  logic        ser_bit   = ser_a & ser_b;
	wire  logic        clk_rise  = shift_clk & ~shift_clk_q;
	wire  logic        room      = ~tail_v_q;
	// A rise that meets a full buffer is parked; only one is held, so a later rise while still full replaces it.
	wire  logic        want      = clk_rise | pend_q;
	wire  logic        do_shift  = want & room & stage_wipe_n;
	wire  logic        shift_bit = pend_q ? pend_bit_q : ser_bit;
	wire  logic        pop       = head_v_q & word_ready;

	// The oldest stage falls off the end; nothing reports it.
	genvar i;
	generate
		for (i = 0; i < STAGES; i++) begin : g_stage
			if (i == 0) begin : g_first
				assign stage_d[i] = shift_bit;
			end else begin : g_rest
				assign stage_d[i] = stage_q[i-1];
			end
		end
	endgenerate

	assign stage_out      = stage_q;
	assign last_stage_out = stage_q[STAGES-1];
	assign word_data      = head_q;
	assign word_valid     = head_v_q;
	assign buf_full       = tail_v_q;

	// Wipe is seen at the next system clock edge, since pins are taken as synchronous.
	always_ff @(posedge clock) begin
		if (!reset_n || !stage_wipe_n) begin
			stage_q <= {STAGES{SIPO_STAGE_RESET}};
		end else if (do_shift) begin
			stage_q <= stage_d;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			shift_clk_q <= SIPO_OFF;
			pend_q      <= SIPO_OFF;
			pend_bit_q  <= SIPO_FIRST_STAGE;
		end else begin
			shift_clk_q <= shift_clk;
			if (!stage_wipe_n || do_shift) begin
				pend_q <= SIPO_OFF;
			end else if (clk_rise) begin
				pend_q     <= SIPO_SET;
				pend_bit_q <= ser_bit;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			head_q   <= {STAGES{SIPO_STAGE_RESET}};
			tail_q   <= {STAGES{SIPO_STAGE_RESET}};
			head_v_q <= SIPO_OFF;
			tail_v_q <= SIPO_OFF;
		end else if (do_shift && pop) begin
			if (tail_v_q) begin
				head_q <= tail_q;
				tail_q <= stage_d;
			end else begin
				head_q <= stage_d;
			end
		end else if (do_shift) begin
			if (!head_v_q) begin
				head_q   <= stage_d;
				head_v_q <= SIPO_SET;
			end else begin
				tail_q   <= stage_d;
				tail_v_q <= SIPO_SET;
			end
		end else if (pop) begin
			head_q   <= tail_q;
			head_v_q <= tail_v_q;
			tail_v_q <= SIPO_OFF;
		end
	end
endmodule : sipo_shift8

// [verif/sipo_chk_checker.sv]
module sipo_chk (input wire logic clock, reset_n, ser_a, ser_b, shift_clk, stage_wipe_n, buf_full, word_valid,
	last_stage_out, input wire logic [7:0] stage_out);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_rise; stage_wipe_n && shift_clk && !$past(shift_clk) && !buf_full; endsequence
	property p_shift; s_rise |=> stage_out == {$past(stage_out[6:0]), $past(ser_a & ser_b)}; endproperty
	a_shift: assert property (p_shift) else $error("Shift result wrong.");
	property p_push; s_rise |=> word_valid; endproperty
	a_push: assert property (p_push) else $error("No word after shift.");
	property p_wipe; !stage_wipe_n |=> stage_out == 8'h00; endproperty
	a_wipe: assert property (p_wipe) else $error("Wipe did not zero stages.");
	// Edges around a full buffer are left out, since a parked shift lands later.
	property p_hold; stage_wipe_n && !(shift_clk && !$past(shift_clk)) && !buf_full && !$past(buf_full)
		|=> $stable(stage_out); endproperty
	a_hold: assert property (p_hold) else $error("Stages moved without rise.");
	property p_last; last_stage_out == stage_out[7]; endproperty
	a_last: assert property (p_last) else $error("Last stage output wrong.");
	property p_wipe_hold; !stage_wipe_n && $past(!stage_wipe_n) |-> stage_out == 8'h00; endproperty
	a_wipe_hold: assert property (p_wipe_hold) else $error("Stages moved during wipe.");
endmodule : sipo_chk
bind sipo_shift8 sipo_chk sipo_chk_inst (.*);

// [verif/sipo_host.sv]
module sipo_host (input wire logic clock, output logic ser_a, ser_b, shift_clk);
	timeunit 1ns; timeprecision 1ps;
	initial {ser_a, ser_b, shift_clk} = 3'h0;
	task send(input logic a, b);
		@(posedge clock) #1 {ser_a, ser_b, shift_clk} = {a, b, 1'h1};
		@(posedge clock) #1 shift_clk = 1'h0;
	endtask : send
endmodule : sipo_host

// [verif/sipo_shift8_tb_top.sv]
module sipo_shift8_tb_top;
	timeunit 1ns; timeprecision 1ps;
	logic clock = 0, reset_n = 0, stage_wipe_n = 1, word_ready = 1, ser_a, ser_b, shift_clk, last_stage_out;
	logic word_valid, buf_full;
	logic [7:0] stage_out, word_data, e = 8'h00;
	int error_cnt = 0, cmp_count = 0;
	always #12.5 clock = ~clock;
	sipo_host sipo_host_inst (.*);
	sipo_shift8 sipo_shift8_inst (.*);
	task chk(string n, logic [7:0] x, g);
		cmp_count++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task sh(logic a, b);
		sipo_host_inst.send(a, b);
		e = {e[6:0], a & b};
		chk("stage_out", e, stage_out);
		chk("last_stage_out", {7'h00, e[7]}, {7'h00, last_stage_out});
	endtask : sh
	task t_shift;
		for (int i = 0; i < 10; i++) sh(i % 3 != 1, i % 4 != 2);
	endtask : t_shift
	task t_wipe;
		@(posedge clock) #1 stage_wipe_n = 0;
		sipo_host_inst.send(1, 1);
		e = 8'h00;
		chk("wiped", e, stage_out);
		stage_wipe_n = 1;
	endtask : t_wipe
	task t_buf;
		word_ready = 0;
		sh(1, 1);
		sh(1, 0);
		chk("buf_full", 8'h01, {7'h00, buf_full});
		chk("word_data", 8'h01, word_data);
		sipo_host_inst.send(1, 1);
		chk("parked", e, stage_out);
		word_ready = 1;
		e = {e[6:0], 1'h1};
		repeat (6) @(posedge clock);
		chk("parked_landed", e, stage_out);
		chk("drained", 8'h00, {7'h00, word_valid});
	endtask : t_buf
	task final_report;
		if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (2) @(posedge clock);
		#1 reset_n = 1;
		stage_wipe_n = 0;
		@(posedge clock) #1 stage_wipe_n = 1;
		t_shift;
		t_wipe;
		t_buf;
		final_report;
	end
	initial begin
		#20000 error_cnt++;
		final_report;
	end
endmodule : sipo_shift8_tb_top
